// >>> mio_board.sv
// board model: switches on port_a, floating or pulled port_b, irq switch
`timescale 1ns/1ns
module mio_board (
  input  wire       core_clk_i,
  input  wire [7:0] sw_i,
  input  wire       sw_d0_i,
  input  wire [7:0] a_drv_i,
  input  wire [7:0] a_oen_i,
  input  wire [7:0] b_drv_i,
  input  wire [7:0] b_oen_i,
  input  wire [7:0] b_pull_i,
  input  wire       d_oen0_i,
  output wire [7:0] a_lvl_o,
  output wire [7:0] b_lvl_o,
  output wire       d0_lvl_o
);
  // an unpulled released line must not settle to a lucky value
  reg [7:0] flt_reg = 8'h5A;
  always @(posedge core_clk_i) flt_reg <= ~flt_reg;
  assign a_lvl_o = (a_oen_i & sw_i) | (~a_oen_i & a_drv_i);
  assign b_lvl_o = (~b_oen_i & b_drv_i) | (b_oen_i & (b_pull_i | flt_reg));
  assign d0_lvl_o = d_oen0_i ? sw_d0_i : 1'b0;
endmodule // mio_board

// >>> mio_edge.v
// falling and any-edge detector on synchronised levels
`timescale 1ns/1ns
module mio_edge #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] fall_o,
  output wire [WIDTH-1:0] any_o
);
  reg [WIDTH-1:0] prev_reg;

  // idle high so that a pin held high through reset gives no edge
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      prev_reg <= {WIDTH{1'b1}};
    else
      prev_reg <= level_i;
  end

  assign fall_o = prev_reg & ~level_i;
  assign any_o  = prev_reg ^ level_i;
endmodule // mio_edge

// >>> mio_port.v
// parallel I/O port logic: two bidirectional and three output-only ports
`timescale 1ns/1ns
`include "mio_regs.vh"
module mio_port #(
  parameter WIDTH = 8,
  parameter ADC_N = `MIO_ADC_CHANNELS
) (
  input  wire             core_clk_i,
  input  wire             rstn_i,
  // data-memory port of the core
  input  wire [2:0]       reg_idx_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  input  wire             bit_op_i,
  input  wire [2:0]       bit_sel_i,
  input  wire             bit_val_i,
  input  wire [WIDTH-1:0] reg_wdata_i,
  input  wire             phase_two_i,
  output reg  [WIDTH-1:0] reg_rdata_o,
  // configuration options and shared-function controls
  input  wire [WIDTH-1:0] port_a_pullup_opt_i,
  input  wire [WIDTH-1:0] port_b_pullup_opt_i,
  input  wire [WIDTH-1:0] port_a_wake_opt_i,
  input  wire             pwm_out_0_opt_i,
  input  wire             pwm_out_1_opt_i,
  input  wire             pwm_out_0_i,
  input  wire             pwm_out_1_i,
  input  wire [ADC_N-1:0] adc_pin_sel_i,
  input  wire             ext_irq_en_i,
  input  wire             lcd_drive_enable_i,
  input  wire             timer_ext_mode_i,
  input  wire             power_down_i,
  // pins
  input  wire [WIDTH-1:0] port_a_pin_i,
  output reg  [WIDTH-1:0] port_a_pin_o,
  output reg  [WIDTH-1:0] port_a_pin_oen_o,
  output reg  [WIDTH-1:0] port_a_pullup_o,
  input  wire [WIDTH-1:0] port_b_pin_i,
  output reg  [WIDTH-1:0] port_b_pin_o,
  output reg  [WIDTH-1:0] port_b_pin_oen_o,
  output reg  [WIDTH-1:0] port_b_pullup_o,
  output reg  [WIDTH-1:0] port_c_pin_o,
  output reg  [WIDTH-1:0] port_c_pin_oen_o,
  input  wire             port_d_bit0_pin_i,
  output reg  [WIDTH-1:0] port_d_pin_o,
  output reg  [WIDTH-1:0] port_d_pin_oen_o,
  output reg  [WIDTH-1:0] port_e_pin_o,
  output reg  [WIDTH-1:0] port_e_pin_oen_o,
  // events towards the core
  output wire             timer_ext_clock_pin_o,
  output reg              wake_o,
  output reg              ext_irq_o
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [WIDTH-1:0] port_a_data_reg;
  reg  [WIDTH-1:0] port_a_direction_reg;
  reg  [WIDTH-1:0] port_b_data_reg;
  reg  [WIDTH-1:0] port_b_direction_reg;
  reg  [WIDTH-1:0] port_c_data_reg;
  reg  [WIDTH-1:0] port_d_data_reg;
  reg  [WIDTH-1:0] port_e_data_reg;
  reg  [WIDTH-1:0] port_a_sample_reg;
  reg  [WIDTH-1:0] port_b_sample_reg;
  reg              phase_two_prev_reg;
  reg  [WIDTH-1:0] read_next;
  reg  [WIDTH-1:0] write_next;
  reg  [WIDTH-1:0] port_a_pullup_next;
  reg  [WIDTH-1:0] port_b_pullup_next;
  reg  [WIDTH-1:0] adc_mask;
  wire             phase_two_rise;
  wire [WIDTH-1:0] bit_mask;
  wire             irq_pin_mode;
  wire [WIDTH-1:0] pwm_sel;
  wire [WIDTH-1:0] pwm_level;
  wire [WIDTH-1:0] port_a_sync;
  wire [WIDTH-1:0] port_a_fall;
  wire             irq_sync;
  wire             irq_any;
  genvar           g;

  // ****************************************************************
  // input sampling
  // ****************************************************************
  // sample at phase_two
  assign phase_two_rise = phase_two_i & ~phase_two_prev_reg;

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_two_prev_reg <= 1'b0;
      port_a_sample_reg  <= `MIO_RST_ONES;
      port_b_sample_reg  <= `MIO_RST_ONES;
    end else begin
      phase_two_prev_reg <= phase_two_i;
      if (phase_two_rise) begin
        port_a_sample_reg <= port_a_pin_i;
        port_b_sample_reg <= port_b_pin_i;
      end
    end
  end

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  always @* begin
    case (reg_idx_i)
      `MIO_IDX_PORT_A_DATA:
        read_next = (port_a_direction_reg & port_a_sample_reg) |
                    (~port_a_direction_reg & port_a_data_reg);
      `MIO_IDX_PORT_A_DIR:  read_next = port_a_direction_reg;
      `MIO_IDX_PORT_B_DATA:
        read_next = (port_b_direction_reg & port_b_sample_reg) |
                    (~port_b_direction_reg & port_b_data_reg);
      `MIO_IDX_PORT_B_DIR:  read_next = port_b_direction_reg;
      `MIO_IDX_PORT_C_DATA: read_next = port_c_data_reg;
      `MIO_IDX_PORT_D_DATA: read_next = port_d_data_reg;
      `MIO_IDX_PORT_E_DATA: read_next = port_e_data_reg;
      default:              read_next = `MIO_RD_UNUSED;
    endcase
  end

  assign bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << bit_sel_i;

  always @* begin
    if (bit_op_i)
      write_next = bit_val_i ? (read_next | bit_mask)
                             : (read_next & ~bit_mask);
    else
      write_next = reg_wdata_i;
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      reg_rdata_o <= `MIO_RD_UNUSED;
    else if (reg_rd_i)
      reg_rdata_o <= read_next;
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_a_data_reg      <= `MIO_RST_ONES;
      port_a_direction_reg <= `MIO_RST_ONES;
      port_b_data_reg      <= `MIO_RST_ONES;
      port_b_direction_reg <= `MIO_RST_ONES;
      port_c_data_reg      <= `MIO_RST_PORT_C;
      port_d_data_reg      <= `MIO_RST_ONES;
      port_e_data_reg      <= `MIO_RST_ONES;
    end else if (reg_wr_i) begin
      case (reg_idx_i)
        `MIO_IDX_PORT_A_DATA: port_a_data_reg      <= write_next;
        `MIO_IDX_PORT_A_DIR:  port_a_direction_reg <= write_next;
        `MIO_IDX_PORT_B_DATA: port_b_data_reg      <= write_next;
        `MIO_IDX_PORT_B_DIR:  port_b_direction_reg <= write_next;
        `MIO_IDX_PORT_C_DATA: port_c_data_reg      <= write_next;
        `MIO_IDX_PORT_D_DATA: port_d_data_reg      <= write_next;
        `MIO_IDX_PORT_E_DATA: port_e_data_reg      <= write_next;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // option and waveform per pin; only two pins can carry a pwm
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pwm
      if (g == `MIO_BIT_PWM_OUT_0) begin : g_p0
        assign pwm_sel[g]   = pwm_out_0_opt_i;
        assign pwm_level[g] = pwm_out_0_i;
      end else if (g == `MIO_BIT_PWM_OUT_1) begin : g_p1
        assign pwm_sel[g]   = pwm_out_1_opt_i;
        assign pwm_level[g] = pwm_out_1_i;
      end else begin : g_none
        assign pwm_sel[g]   = 1'b0;
        assign pwm_level[g] = 1'b0;
      end
    end
  endgenerate

  assign irq_pin_mode = ext_irq_en_i & ~lcd_drive_enable_i &
                        port_d_data_reg[`MIO_BIT_IRQ_PIN];

  always @* begin
    adc_mask = {WIDTH{1'b0}};
    adc_mask[ADC_N-1:0] = adc_pin_sel_i;
  end

  always @* begin
    port_a_pullup_next = port_a_pullup_opt_i & port_a_direction_reg;
    port_b_pullup_next = port_b_pullup_opt_i & port_b_direction_reg &
                         ~adc_mask;
  end

  // registered so pins change one clock after the latch, glitch free
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_a_pin_o     <= `MIO_RST_ONES;
      port_a_pin_oen_o <= `MIO_RST_ONES;
      port_a_pullup_o  <= {WIDTH{1'b0}};
      port_b_pin_o     <= `MIO_RST_ONES;
      port_b_pin_oen_o <= `MIO_RST_ONES;
      port_b_pullup_o  <= {WIDTH{1'b0}};
      port_c_pin_o     <= {WIDTH{1'b0}};
      port_c_pin_oen_o <= `MIO_RST_ONES;
      port_d_pin_o     <= {WIDTH{1'b0}};
      port_d_pin_oen_o <= `MIO_RST_ONES;
      port_e_pin_o     <= {WIDTH{1'b0}};
      port_e_pin_oen_o <= `MIO_RST_ONES;
    end else begin
      port_a_pin_o <= (pwm_sel & pwm_level) | (~pwm_sel & port_a_data_reg);
      port_a_pin_oen_o <= port_a_direction_reg;
      port_a_pullup_o  <= port_a_pullup_next;
      port_b_pin_o     <= port_b_data_reg;
      port_b_pin_oen_o <= port_b_direction_reg | adc_mask;
      port_b_pullup_o  <= port_b_pullup_next;
      port_c_pin_o     <= {WIDTH{1'b0}};
      port_c_pin_oen_o <= port_c_data_reg;
      port_d_pin_o     <= {WIDTH{1'b0}};
      port_d_pin_oen_o <= port_d_data_reg;
      port_e_pin_o     <= {WIDTH{1'b0}};
      port_e_pin_oen_o <= port_e_data_reg;
    end
  end

  // ****************************************************************
  // edge events
  // ****************************************************************
  // synchronise before edges
  mio_sync #(
    .WIDTH (WIDTH)
  ) u_sync_a (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_a_pin_i),
    .sync_o     (port_a_sync)
  );

  mio_sync #(
    .WIDTH (1)
  ) u_sync_irq (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (port_d_bit0_pin_i),
    .sync_o     (irq_sync)
  );

  mio_edge #(
    .WIDTH (WIDTH)
  ) u_edge_a (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .level_i    (port_a_sync),
    .fall_o     (port_a_fall),
    .any_o      ()
  );

  mio_edge #(
    .WIDTH (1)
  ) u_edge_irq (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .level_i    (irq_sync),
    .fall_o     (),
    .any_o      (irq_any)
  );

  assign timer_ext_clock_pin_o = port_a_sync[`MIO_BIT_TIMER] &
                                 timer_ext_mode_i;

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o    <= 1'b0;
      ext_irq_o <= 1'b0;
    end else begin
      wake_o    <= power_down_i & (|(port_a_fall & port_a_wake_opt_i));
      ext_irq_o <= irq_pin_mode & irq_any;
    end
  end

endmodule // mio_port

// >>> mio_port_chk.sv
// assertion checker on the pins and events of the port block
`timescale 1ns/1ns
module mio_port_chk (
  input wire       core_clk_i,
  input wire       rstn_i,
  input wire [2:0] reg_idx_i,
  input wire       reg_wr_i,
  input wire       bit_op_i,
  input wire [7:0] reg_wdata_i,
  input wire [5:0] adc_pin_sel_i,
  input wire       ext_irq_en_i,
  input wire       lcd_drive_enable_i,
  input wire       power_down_i,
  input wire       port_d_bit0_pin_i,
  input wire [7:0] port_a_pin_oen_o,
  input wire [7:0] port_a_pullup_o,
  input wire [7:0] port_b_pin_o,
  input wire [7:0] port_b_pullup_o,
  input wire [7:0] port_c_pin_o,
  input wire [7:0] port_c_pin_oen_o,
  input wire [7:0] port_d_pin_o,
  input wire [7:0] port_d_pin_oen_o,
  input wire [7:0] port_e_pin_o,
  input wire       wake_o,
  input wire       ext_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_dir_a;
    reg_wr_i && !bit_op_i && reg_idx_i == 3'h1
      |-> ##2 port_a_pin_oen_o == $past(reg_wdata_i, 2);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("dir to oen");
  property p_out_c;
    reg_wr_i && !bit_op_i && reg_idx_i == 3'h4
      |-> ##2 port_c_pin_oen_o == $past(reg_wdata_i, 2);
  endproperty
  a_out_c: assert property (p_out_c) else $error("c oen");
  property p_sink;
    (port_c_pin_o | port_d_pin_o | port_e_pin_o) == 8'h00;
  endproperty
  a_sink: assert property (p_sink) else $error("sink level");
  property p_hold_b;
    !reg_wr_i ##1 !reg_wr_i |=> $stable(port_b_pin_o);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("b moved");
  property p_wake;
    wake_o |-> $past(power_down_i) ##1 !wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse");
  property p_irq;
    ext_irq_o |-> $past(ext_irq_en_i) && !$past(lcd_drive_enable_i)
      ##1 !ext_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq gate");
  property p_irq_edge;
    ext_irq_en_i && !lcd_drive_enable_i && port_d_pin_oen_o[0]
      && $changed(port_d_bit0_pin_i) |-> ##[2:4] ext_irq_o;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("no irq");
  property p_adc_pull;
    (port_b_pullup_o[5:0] & adc_pin_sel_i & $past(adc_pin_sel_i)) == 6'h00;
  endproperty
  a_adc_pull: assert property (p_adc_pull) else $error("adc pull");
  property p_pull_in;
    (port_a_pullup_o & ~port_a_pin_oen_o) == 8'h00;
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull on out");
  c_wake: cover property (wake_o);
  c_irq: cover property (ext_irq_o);
  c_mixed: cover property (port_a_pin_oen_o == 8'hF0);
endmodule // mio_port_chk

// >>> mio_port_test.sv
// self-checking bench for the port block with its board model
`timescale 1ns/1ns
module mio_port_test;
  reg        core_clk_i, rstn_i, reg_wr_i, reg_rd_i, bit_op_i, bit_val_i;
  reg        phase_two_i, pwm_out_0_opt_i, pwm_out_1_opt_i, pwm_out_0_i, pwm_out_1_i;
  reg        ext_irq_en_i, lcd_drive_enable_i, timer_ext_mode_i, sw_d0;
  reg        power_down_i;
  reg  [2:0] reg_idx_i, bit_sel_i;
  reg  [5:0] adc_pin_sel_i;
  reg  [7:0] reg_wdata_i, port_a_pullup_opt_i, port_b_pullup_opt_i, sw;
  reg  [7:0] port_a_wake_opt_i;
  wire [7:0] reg_rdata_o, port_a_pin_i, port_b_pin_i, port_a_pin_o;
  wire [7:0] port_a_pin_oen_o, port_a_pullup_o, port_b_pin_o;
  wire [7:0] port_b_pin_oen_o, port_b_pullup_o, port_c_pin_o;
  wire [7:0] port_c_pin_oen_o, port_d_pin_o, port_d_pin_oen_o;
  wire [7:0] port_e_pin_o, port_e_pin_oen_o;
  wire       port_d_bit0_pin_i, timer_ext_clock_pin_o, wake_o, ext_irq_o;
  integer    mismatches, n_compared, nw, ni, k;
  mio_port i_mio_port (.*);
  mio_board i_mio_board (.core_clk_i(core_clk_i), .sw_i(sw), .sw_d0_i(sw_d0),
    .a_drv_i(port_a_pin_o), .a_oen_i(port_a_pin_oen_o),
    .b_drv_i(port_b_pin_o), .b_oen_i(port_b_pin_oen_o),
    .b_pull_i(port_b_pullup_o), .d_oen0_i(port_d_pin_oen_o[0]),
    .a_lvl_o(port_a_pin_i), .b_lvl_o(port_b_pin_i),
    .d0_lvl_o(port_d_bit0_pin_i));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input [2:0] idx, input [7:0] d, input bop, input [2:0] b);
    begin
      @(posedge core_clk_i);
      reg_idx_i <= idx;
      reg_wdata_i <= d;
      bit_op_i <= bop;
      bit_sel_i <= b;
      bit_val_i <= d[0];
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] idx, input [7:0] exp);
    begin
      @(posedge core_clk_i);
      reg_idx_i <= idx;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      chk(reg_rdata_o, exp);
    end
  endtask
  task phase;
    begin
      @(posedge core_clk_i);
      phase_two_i <= 1'b1;
      cyc(1);
      phase_two_i <= 1'b0;
      cyc(3);
    end
  endtask
  task pulses(input integer n);
    begin
      nw = 0;
      ni = 0;
      repeat (n) begin
        @(posedge core_clk_i);
        nw = nw + wake_o;
        ni = ni + ext_irq_o;
      end
    end
  endtask
  task t_reset;
    begin
      for (k = 0; k < 7; k = k + 1) rd(k[2:0], (k == 4) ? 8'h00 : 8'hFF);
      chk(port_c_pin_oen_o & 8'hFF, 8'h00);
      chk(port_a_pin_oen_o & port_d_pin_oen_o & port_e_pin_oen_o, 8'hFF);
    end
  endtask
  task t_io;
    begin
      sw <= 8'h3C;
      wr(3'h1, 8'hF0, 1'b0, 3'h0);
      wr(3'h0, 8'hA5, 1'b0, 3'h0);
      wr(3'h2, 8'h81, 1'b0, 3'h0);
      cyc(2);
      chk(port_a_pin_oen_o, 8'hF0);
      chk({4'h0, port_a_pin_o[3:0]}, 8'h05);
      phase;
      sw <= 8'hC3;
      cyc(4);
      rd(3'h0, 8'h35);
      phase;
      rd(3'h0, 8'hC5);
    end
  endtask
  task t_rmw;
    begin
      wr(3'h0, 8'h01, 1'b1, 3'h1);
      wr(3'h1, 8'h00, 1'b0, 3'h0);
      cyc(2);
      chk(port_a_pin_o, 8'hC7);
      wr(3'h1, 8'hFF, 1'b0, 3'h0);
    end
  endtask
  task t_out;
    begin
      wr(3'h4, 8'hA5, 1'b0, 3'h0);
      wr(3'h5, 8'h3C, 1'b0, 3'h0);
      wr(3'h6, 8'h0F, 1'b0, 3'h0);
      wr(3'h7, 8'h00, 1'b0, 3'h0);
      cyc(2);
      chk(port_c_pin_oen_o, 8'hA5);
      chk(port_d_pin_oen_o, 8'h3C);
      chk(port_e_pin_oen_o | port_c_pin_o | port_e_pin_o, 8'h0F);
      rd(3'h7, 8'h00);
      rd(3'h5, 8'h3C);
    end
  endtask
  task t_wake;
    begin
      sw <= 8'hFF;
      port_a_wake_opt_i <= 8'h04;
      power_down_i <= 1'b1;
      cyc(6);
      sw <= 8'hFE;
      pulses(8);
      chk(nw, 0);
      sw <= 8'hFA;
      pulses(8);
      chk(nw, 1);
      power_down_i <= 1'b0;
      sw <= 8'hFF;
      cyc(6);
      sw <= 8'hFB;
      pulses(8);
      chk(nw, 0);
      timer_ext_mode_i <= 1'b1;
      sw <= 8'hFF;
      cyc(5);
      chk({7'h0, timer_ext_clock_pin_o}, 8'h01);
      timer_ext_mode_i <= 1'b0;
      cyc(1);
      chk({7'h0, timer_ext_clock_pin_o}, 8'h00);
    end
  endtask
  task t_irq;
    begin
      wr(3'h5, 8'hFF, 1'b0, 3'h0);
      ext_irq_en_i <= 1'b1;
      // release of the pin from sinking gives one edge; let it pass
      cyc(8);
      sw_d0 <= 1'b0;
      pulses(8);
      chk(ni, 1);
      sw_d0 <= 1'b1;
      pulses(8);
      chk(ni, 1);
      lcd_drive_enable_i <= 1'b1;
      cyc(2);
      sw_d0 <= 1'b0;
      pulses(8);
      chk(ni, 0);
    end
  endtask
  task t_pull;
    begin
      adc_pin_sel_i <= 6'h3F;
      pwm_out_0_opt_i <= 1'b1;
      pwm_out_0_i <= 1'b1;
      wr(3'h1, 8'hEF, 1'b0, 3'h0);
      wr(3'h0, 8'h00, 1'b0, 3'h0);
      cyc(2);
      chk(port_a_pullup_o, 8'hEF);
      chk(port_b_pullup_o, 8'hC0);
      chk({7'h0, port_a_pin_o[4]}, 8'h01);
      wr(3'h1, 8'hFF, 1'b0, 3'h0);
      cyc(2);
      chk({7'h0, port_a_pin_oen_o[4]}, 8'h01);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, bit_op_i, bit_val_i, phase_two_i} = 6'h00;
    {pwm_out_0_opt_i, pwm_out_1_opt_i, pwm_out_0_i, pwm_out_1_i, ext_irq_en_i} = 5'h00;
    {lcd_drive_enable_i, timer_ext_mode_i, power_down_i} = 3'h0;
    {reg_idx_i, bit_sel_i, adc_pin_sel_i, reg_wdata_i} = 20'h0_0000;
    {port_a_pullup_opt_i, port_b_pullup_opt_i, sw} = 24'hFF_FFFF;
    port_a_wake_opt_i = 8'h00;
    sw_d0 = 1'b1;
    mismatches = 0;
    n_compared = 0;
    cyc(5);
    rstn_i <= 1'b1;
    t_reset;
    t_io;
    t_rmw;
    t_out;
    t_wake;
    t_irq;
    t_pull;
    report_and_stop;
  end
endmodule // mio_port_test
bind mio_port mio_port_chk i_mio_port_chk (.*);

// >>> mio_regs.vh
// register indices, reset values and pin-sharing constants for the port block
`ifndef MIO_REGS_VH
`define MIO_REGS_VH

// ****************************************************************
// register indices on the internal data-memory port
// ****************************************************************
`define MIO_IDX_PORT_A_DATA  3'h0
`define MIO_IDX_PORT_A_DIR   3'h1
`define MIO_IDX_PORT_B_DATA  3'h2
`define MIO_IDX_PORT_B_DIR   3'h3
`define MIO_IDX_PORT_C_DATA  3'h4
`define MIO_IDX_PORT_D_DATA  3'h5
`define MIO_IDX_PORT_E_DATA  3'h6

// ****************************************************************
// reset values
// ****************************************************************
`define MIO_RST_ONES         8'hFF
`define MIO_RST_PORT_C       8'h00
`define MIO_RD_UNUSED        8'h00

// ****************************************************************
// pin positions of shared functions
// ****************************************************************
`define MIO_BIT_EXT_IRQ      3
`define MIO_BIT_TIMER        2
`define MIO_BIT_IRQ_PIN      0
`define MIO_BIT_PWM_OUT_0         4
`define MIO_BIT_PWM_OUT_1         5
`define MIO_ADC_CHANNELS     6
`define MIO_SYNC_STAGES      2

`endif

// >>> mio_sync.v
// two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/1ns
module mio_sync #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_reg <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule // mio_sync
